// ==== pgpc_defs.vh ====
`ifndef PGPC_DEFS_VH
`define PGPC_DEFS_VH

// Register word addresses (byte address = 4 * word)
`define PGPC_A_CMD 4'h0
`define PGPC_A_REPLY 4'h1
`define PGPC_A_STATUS 4'h2
`define PGPC_A_IRQ_STAT 4'h3
`define PGPC_A_IRQ_MASK 4'h4
`define PGPC_A_BOOT 4'h5

// Command word fields
`define PGPC_CMD_OP_LSB 28
`define PGPC_OP_SET2 4'h1
`define PGPC_OP_SET3 4'h2
`define PGPC_OP_READ 4'h3
`define PGPC_OP_STORE 4'h4

// Pin configuration byte fields
`define PGPC_CFG_FUNC 3
`define PGPC_MODE_PD 3'h0
`define PGPC_MODE_STRONG 3'h1
`define PGPC_MODE_HIZ 3'h2
`define PGPC_MODE_PU 3'h3
`define PGPC_MODE_SLOW_HI 3'h4
`define PGPC_MODE_SLOW 3'h5
`define PGPC_MODE_RSVD 3'h6
`define PGPC_MODE_SLOW_LO 3'h7

// Level and pin-count limits
`define PGPC_LEVEL_HIGH 8'h64
`define PGPC_NPINS 5

// Factory boot config: all pins default function; 0..1 hi-Z, 2..3 strong, 4 pull-down
`define PGPC_BOOT_CFG0 8'h02
`define PGPC_BOOT_CFG1 8'h02
`define PGPC_BOOT_CFG2 8'h01
`define PGPC_BOOT_CFG3 8'h01
`define PGPC_BOOT_CFG4 8'h00

// Timing
`define PGPC_CLK_HZ 250000000
`define PGPC_PWM_HZ 100
`define PGPC_SAMPLE_HZ 32
`define PGPC_PWM_STEP_CYC (`PGPC_CLK_HZ / (`PGPC_PWM_HZ * 100))
`define PGPC_SAMPLE_CYC (`PGPC_CLK_HZ / `PGPC_SAMPLE_HZ)

// Interrupt bits
`define PGPC_IRQ_EDGE 0
`define PGPC_IRQ_REPLY 1
`define PGPC_IRQ_BADCMD 2

`endif

// ==== pgpc_gpio.v ====
`timescale 1ns/1ps
`include "pgpc_defs.vh"

module pgpc_gpio #(
  parameter SAMPLE_CYC = `PGPC_SAMPLE_CYC,
  parameter PWM_STEP_CYC = `PGPC_PWM_STEP_CYC
) (
  input wire sys_clk,
  input wire rst_n,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg irq,
  input wire [4:0] pin_in,
  output reg [4:0] pin_out,
  output reg [4:0] pin_oe,
  output reg [4:0] pin_pull_up,
  output reg [4:0] pin_pull_down,
  output reg [4:0] pin_slow,
  input wire [4:0] dflt_out,
  input wire [4:0] dflt_oe,
  output reg [4:0] dflt_in
);

////////////////////////////////////////////////////////////////////////////
// Bus slave: one wait cycle, then the answer
reg ack_q;
wire req = (avs_read | avs_write) & ~ack_q;
wire wr_go = avs_write & ack_q;
wire rd_go = avs_read & ack_q;

// Per-pin stores, reply and interrupt registers
reg [7:0] level_q [0:4];
reg [3:0] cfg_q [0:4];
reg [3:0] boot_q [0:4];
reg [4:0] rise_q;
reg [4:0] fall_q;
reg [31:0] reply_q;
reg reply_valid_q;
reg [2:0] irq_stat_q;
reg [2:0] irq_mask_q;

wire [3:0] op = avs_writedata[31:28];
wire [7:0] b_idx = avs_writedata[7:0];
wire [7:0] b_lvl = avs_writedata[15:8];
wire [7:0] b_cfg = avs_writedata[23:16];
wire cmd_wr = wr_go && avs_address == `PGPC_A_CMD;
wire idx_ok = b_idx < `PGPC_NPINS;
wire lvl_ok = b_lvl <= `PGPC_LEVEL_HIGH;
wire cfg_ok = b_cfg[7:4] == 4'h0 &&
  b_cfg[2:0] != `PGPC_MODE_RSVD;
wire set_ok = cmd_wr && idx_ok && lvl_ok &&
  (op == `PGPC_OP_SET2 || (op == `PGPC_OP_SET3 && cfg_ok));
wire rd_ok = cmd_wr && op == `PGPC_OP_READ && idx_ok;
wire st_ok = cmd_wr && op == `PGPC_OP_STORE;
wire bad = cmd_wr && !set_ok && !rd_ok && !st_ok;
wire [2:0] rd_idx = b_idx[2:0];

////////////////////////////////////////////////////////////////////////////
// Timebases
reg [31:0] samp_cnt_q;
reg samp_tick_q;
reg [31:0] step_cnt_q;
reg [6:0] phase_q;

always @(posedge sys_clk or negedge rst_n) begin
  if (!rst_n) begin
    samp_cnt_q <= 32'h0;
    samp_tick_q <= 1'b0;
    step_cnt_q <= 32'h0;
    phase_q <= 7'h0;
  end else begin
    samp_tick_q <= 1'b0;
    if (samp_cnt_q == SAMPLE_CYC - 1) begin
      samp_cnt_q <= 32'h0;
      samp_tick_q <= 1'b1;
    end else begin
      samp_cnt_q <= samp_cnt_q + 32'h1;
    end
    if (step_cnt_q == PWM_STEP_CYC - 1) begin
      step_cnt_q <= 32'h0;
      // 100 steps of 1 percent make one 100 Hz period
      phase_q <= (phase_q == 7'h63) ? 7'h0 : phase_q + 7'h1;
    end else begin
      step_cnt_q <= step_cnt_q + 32'h1;
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// Input synchroniser and sampler
reg [4:0] sync1_q;
reg [4:0] sync2_q;
reg [4:0] samp_q;

always @(posedge sys_clk or negedge rst_n) begin
  if (!rst_n) begin
    sync1_q <= 5'h0;
    sync2_q <= 5'h0;
    samp_q <= 5'h0;
    dflt_in <= 5'h0;
  end else begin
    sync1_q <= pin_in;
    sync2_q <= sync1_q;
    dflt_in <= sync2_q;
    if (samp_tick_q)
      samp_q <= sync2_q;
  end
end

////////////////////////////////////////////////////////////////////////////
// Per-pin state, edge flags and pad drive
reg booted_q;
genvar g;
generate
  for (g = 0; g < 5; g = g + 1) begin : pin_g
    // Factory bytes are 8 bits wide; only the low nibble is stored
    wire [7:0] boot_rst = (g == 0) ? `PGPC_BOOT_CFG0 :
      (g == 1) ? `PGPC_BOOT_CFG1 : (g == 2) ? `PGPC_BOOT_CFG2 :
      (g == 3) ? `PGPC_BOOT_CFG3 : `PGPC_BOOT_CFG4;
    wire sel = rd_idx == g;
    wire new_rise = samp_tick_q & sync2_q[g] & ~samp_q[g];
    wire new_fall = samp_tick_q & ~sync2_q[g] & samp_q[g];
    wire lvl_bit = (level_q[g] == 8'h0) ? 1'b0 :
      (level_q[g] >= `PGPC_LEVEL_HIGH) ? 1'b1 :
      ({1'b0, phase_q} < level_q[g]);
    wire user = cfg_q[g][`PGPC_CFG_FUNC];
    wire val = user ? lvl_bit : dflt_out[g];
    wire [2:0] md = cfg_q[g][2:0];

    always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        level_q[g] <= 8'h0;
        cfg_q[g] <= boot_rst[3:0];
        boot_q[g] <= boot_rst[3:0];
        rise_q[g] <= 1'b0;
        fall_q[g] <= 1'b0;
      end else begin
        if (!booted_q)
          cfg_q[g] <= boot_q[g];
        else if (set_ok && sel) begin
          level_q[g] <= b_lvl;
          if (op == `PGPC_OP_SET3)
            cfg_q[g] <= b_cfg[3:0];
        end
        if (st_ok)
          boot_q[g] <= cfg_q[g];
        // New edge wins over the clear from a read
        if (new_rise)
          rise_q[g] <= 1'b1;
        else if (rd_ok && sel)
          rise_q[g] <= 1'b0;
        if (new_fall)
          fall_q[g] <= 1'b1;
        else if (rd_ok && sel)
          fall_q[g] <= 1'b0;
      end
    end

    // Default function's enable masks the drive that the mode sets when not user
    always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        pin_out[g] <= 1'b0;
        pin_oe[g] <= 1'b0;
        pin_pull_up[g] <= 1'b0;
        pin_pull_down[g] <= 1'b0;
        pin_slow[g] <= 1'b0;
      end else begin
        pin_out[g] <= val;
        pin_slow[g] <= md[2];
        pin_pull_up[g] <= md == `PGPC_MODE_PU && val;
        pin_pull_down[g] <= md == `PGPC_MODE_PD && !val;
        case (md)
          `PGPC_MODE_PD: pin_oe[g] <= val;
          `PGPC_MODE_STRONG: pin_oe[g] <= 1'b1;
          `PGPC_MODE_HIZ: pin_oe[g] <= 1'b0;
          `PGPC_MODE_PU: pin_oe[g] <= !val;
          `PGPC_MODE_SLOW_HI: pin_oe[g] <= val;
          `PGPC_MODE_SLOW: pin_oe[g] <= 1'b1;
          `PGPC_MODE_SLOW_LO: pin_oe[g] <= !val;
          default: pin_oe[g] <= 1'b0;
        endcase
        if (!user && !dflt_oe[g])
          pin_oe[g] <= 1'b0;
      end
    end
  end
endgenerate

////////////////////////////////////////////////////////////////////////////
// Command results, interrupts and bus answer
wire [7:0] st_byte = {5'h0, rise_q[rd_idx], fall_q[rd_idx],
  samp_q[rd_idx]};
wire any_edge = samp_tick_q && (sync2_q != samp_q);
wire [2:0] ev = {bad, rd_ok, any_edge};
wire [2:0] w1c = (wr_go && avs_address == `PGPC_A_IRQ_STAT) ?
  avs_writedata[2:0] : 3'h0;

always @(posedge sys_clk or negedge rst_n) begin
  if (!rst_n) begin
    ack_q <= 1'b0;
    avs_waitrequest <= 1'b1;
    avs_readdata <= 32'h0;
    reply_q <= 32'h0;
    reply_valid_q <= 1'b0;
    irq_stat_q <= 3'h0;
    irq_mask_q <= 3'h0;
    irq <= 1'b0;
    booted_q <= 1'b0;
  end else begin
    booted_q <= 1'b1;
    ack_q <= req;
    avs_waitrequest <= ~req;
    if (rd_ok) begin
      reply_q <= {{4'h0, cfg_q[rd_idx]}, level_q[rd_idx], st_byte,
        b_idx};
      reply_valid_q <= 1'b1;
    end
    // Set wins over write-one-to-clear
    irq_stat_q <= (irq_stat_q & ~w1c) | ev;
    if (wr_go && avs_address == `PGPC_A_IRQ_MASK)
      irq_mask_q <= avs_writedata[2:0];
    irq <= |(irq_stat_q & irq_mask_q);
    if (req && avs_read) begin
      case (avs_address)
        `PGPC_A_REPLY: avs_readdata <= reply_q;
        `PGPC_A_STATUS: avs_readdata <= {26'h0, reply_valid_q, samp_q};
        `PGPC_A_IRQ_STAT: avs_readdata <= {29'h0, irq_stat_q};
        `PGPC_A_IRQ_MASK: avs_readdata <= {29'h0, irq_mask_q};
        `PGPC_A_BOOT: avs_readdata <= {12'h0, boot_q[4], boot_q[3],
          boot_q[2], boot_q[1], boot_q[0]};
        default: avs_readdata <= 32'h0;
      endcase
    end
    if (rd_go && avs_address == `PGPC_A_REPLY)
      reply_valid_q <= rd_ok;
  end
end

endmodule // pgpc_gpio

// ==== pgpc_properties.sv ====
`timescale 1ns/1ps
module pgpc_properties (
  input wire sys_clk,
  input wire rst_n,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire irq,
  input wire [4:0] pin_out,
  input wire [4:0] pin_oe,
  input wire [4:0] pin_pull_up,
  input wire [4:0] pin_pull_down,
  input wire [4:0] pin_slow
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_req; $rose(avs_read || avs_write); endsequence
  sequence s_ack; !avs_waitrequest ##1 avs_waitrequest; endsequence
  property p_wait_ans; s_req |=> s_ack; endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("no single answer");
  property p_no_early; s_req |-> avs_waitrequest; endproperty
  a_no_early: assert property (p_no_early) else $error("answer too early");
  property p_cause; !avs_waitrequest |-> $past(avs_read || avs_write); endproperty
  a_cause: assert property (p_cause) else $error("answer without request");
  property p_rst; $rose(rst_n) |-> avs_waitrequest && !irq; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_pulls; (pin_pull_up & pin_pull_down) == 5'h0; endproperty
  a_pulls: assert property (p_pulls) else $error("both pulls on");
  property p_drive; (pin_oe & (pin_pull_up | pin_pull_down)) == 5'h0;
  endproperty
  a_drive: assert property (p_drive) else $error("drive and pull");
  property p_slow; (pin_slow & (pin_pull_up | pin_pull_down)) == 5'h0;
  endproperty
  a_slow: assert property (p_slow) else $error("slow pin pulled");
  // High phase of pin 0 lasts at least two clock cycles
  property p_pwm; $rose(pin_out[0]) |=> pin_out[0]; endproperty
  a_pwm: assert property (p_pwm) else $error("runt high pulse");
endmodule // pgpc_properties
bind pgpc_gpio pgpc_properties i_pgpc_properties (.*);

// ==== pgpc_pads.sv ====
`timescale 1ns/1ps
module pgpc_pads (
  input wire sys_clk,
  input wire [4:0] pin_out,
  input wire [4:0] pin_oe,
  input wire [4:0] pin_pull_up,
  input wire [4:0] pin_pull_down,
  input wire [4:0] ext_en,
  input wire [4:0] ext_val,
  output wire [4:0] pin_in
);
  reg [4:0] flt_q = 5'h0;
  // Undriven pads without a pull wander so a stale level never reads back
  always @(posedge sys_clk) flt_q <= ~flt_q;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) |
    (~pin_oe & ~ext_en & (pin_pull_up | (~pin_pull_down & flt_q)));
endmodule // pgpc_pads

// ==== pgpc_gpio_bench.sv ====
`timescale 1ns/1ps
`include "pgpc_defs.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
  err_count++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module pgpc_gpio_bench;
  reg sys_clk = 1'b0;
  reg rst_n = 1'b0;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [3:0] avs_address = 4'h0;
  reg [31:0] avs_writedata = 32'h0;
  reg [4:0] dflt_out = 5'h0;
  reg [4:0] dflt_oe = 5'h0;
  reg [4:0] ext_en = 5'h1f;
  reg [4:0] ext_val = 5'h0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire irq;
  wire [4:0] pin_in, pin_out, pin_oe, pu, pd, slow, dflt_in;
  int err_count = 0;
  int n_compared = 0;
  int i;
  int hi;
  reg [31:0] d;
  reg [7:0] boot [0:4] = '{`PGPC_BOOT_CFG0, `PGPC_BOOT_CFG1,
    `PGPC_BOOT_CFG2, `PGPC_BOOT_CFG3, `PGPC_BOOT_CFG4};
  // {oe, up, down, slow} at level 100 then level 0, by drive mode
  reg [7:0] tbl [0:7] = '{8'h82, 8'h88, 8'h00, 8'h48, 8'h91, 8'h99,
    8'h00, 8'h19};
  reg [31:0] bad [0:4] = '{32'h10000005, 32'h10006500, 32'h20106400,
    32'h200e6400, 32'h30000005};
  always #2 sys_clk = ~sys_clk;
  pgpc_gpio #(.SAMPLE_CYC(16), .PWM_STEP_CYC(2)) i_pgpc_gpio (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .irq(irq),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pull_up(pu), .pin_pull_down(pd), .pin_slow(slow),
    .dflt_out(dflt_out), .dflt_oe(dflt_oe), .dflt_in(dflt_in));
  pgpc_pads i_pgpc_pads (.sys_clk(sys_clk), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pull_up(pu), .pin_pull_down(pd), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in));
  task automatic xfer(input bit w, input [3:0] a, input [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    `CHK(n < 50, 1'b1)
  endtask
  task automatic cmd(input [3:0] op, input [7:0] ix, lv, cf);
    xfer(1'b1, `PGPC_A_CMD, {op, 4'h0, cf, lv, ix});
  endtask
  task automatic rd_pin(input [7:0] ix);
    cmd(`PGPC_OP_READ, ix, 8'h0, 8'h0);
    repeat (2) @(posedge sys_clk);
    xfer(1'b0, `PGPC_A_REPLY, 32'h0);
  endtask
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    give_verdict;
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    for (i = 0; i < 5; i++) begin
      rd_pin(i);
      `CHK(d[31:24], boot[i])
    end
    xfer(1'b0, `PGPC_A_BOOT, 32'h0);
    `CHK(d[19:0], {boot[4][3:0], boot[3][3:0], boot[2][3:0], boot[1][3:0],
      boot[0][3:0]})
    xfer(1'b0, 4'hf, 32'h0);
    `CHK(d, 32'h0)
    cmd(`PGPC_OP_SET3, 8'h0, 8'h64, 8'h09);
    repeat (60) @(posedge sys_clk);
    rd_pin(0);
    `CHK(d, 32'h09640500)
    rd_pin(0);
    `CHK(d[15:8], 8'h01)
    cmd(`PGPC_OP_SET2, 8'h0, 8'h0, 8'h0);
    repeat (60) @(posedge sys_clk);
    rd_pin(0);
    `CHK(d, 32'h09000200)
    for (i = 0; i < 8; i++) if (i != 6) begin
      cmd(`PGPC_OP_SET3, 8'h0, 8'h64, 8'h08 | i);
      repeat (8) @(posedge sys_clk);
      `CHK({pin_oe[0], pu[0], pd[0], slow[0]}, tbl[i][7:4])
      cmd(`PGPC_OP_SET2, 8'h0, 8'h0, 8'h0);
      repeat (8) @(posedge sys_clk);
      `CHK({pin_oe[0], pu[0], pd[0], slow[0]}, tbl[i][3:0])
    end
    cmd(`PGPC_OP_SET3, 8'h0, 8'h0, 8'h0a);
    ext_val <= 5'h01;
    repeat (60) @(posedge sys_clk);
    rd_pin(0);
    `CHK({d[23:16], d[8]}, 9'h001)
    `CHK(dflt_in[0], 1'b1)
    dflt_out <= 5'h01;
    dflt_oe <= 5'h01;
    cmd(`PGPC_OP_SET3, 8'h0, 8'h0, 8'h01);
    repeat (8) @(posedge sys_clk);
    `CHK(pin_out[0] & pin_oe[0], 1'b1)
    cmd(`PGPC_OP_SET3, 8'h0, 8'h19, 8'h09);
    repeat (400) @(posedge sys_clk);
    hi = 0;
    repeat (200) begin
      @(posedge sys_clk);
      hi += pin_out[0];
    end
    `CHK(hi, 50)
    xfer(1'b1, `PGPC_A_IRQ_MASK, 32'h4);
    for (i = 0; i < 5; i++) begin
      xfer(1'b1, `PGPC_A_CMD, bad[i]);
      repeat (3) @(posedge sys_clk);
      `CHK(irq, 1'b1)
      xfer(1'b1, `PGPC_A_IRQ_STAT, 32'h4);
      repeat (3) @(posedge sys_clk);
      `CHK(irq, 1'b0)
    end
    rd_pin(0);
    `CHK(d[31:16], 16'h0919)
    xfer(1'b1, `PGPC_A_IRQ_MASK, 32'h0);
    xfer(1'b1, `PGPC_A_CMD, bad[0]);
    repeat (3) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    xfer(1'b0, `PGPC_A_IRQ_STAT, 32'h0);
    `CHK(d[2], 1'b1)
    cmd(`PGPC_OP_STORE, 8'h0, 8'h0, 8'h0);
    xfer(1'b0, `PGPC_A_BOOT, 32'h0);
    `CHK(d[3:0], 4'h9)
    give_verdict;
  end
endmodule // pgpc_gpio_bench
